// ---- hdl/dow_top.sv ----
`default_nettype none

module dow_top #(
    parameter int unsigned CYCLES_PER_SEC = dow_pkg::CYCLES_PER_SEC
) (
    input wire logic clk,                            // 250 MHz clock
    input wire logic rst_n,                          // sync reset, low
    // axi4-lite slave
    input wire logic [dow_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid,                  // write addr valid
    output logic s_axi_awready,                      // write addr ready
    input wire logic [31:0] s_axi_wdata,             // write data
    input wire logic [3:0] s_axi_wstrb,              // byte enables
    input wire logic s_axi_wvalid,                   // write data valid
    output logic s_axi_wready,                       // write data ready
    output logic [1:0] s_axi_bresp,                  // write response
    output logic s_axi_bvalid,                       // response valid
    input wire logic s_axi_bready,                   // response ready
    input wire logic [dow_pkg::ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid,                  // read addr valid
    output logic s_axi_arready,                      // read addr ready
    output logic [31:0] s_axi_rdata,                 // read data
    output logic [1:0] s_axi_rresp,                  // read response
    output logic s_axi_rvalid,                       // read data valid
    input wire logic s_axi_rready,                   // read data ready
    // serial protocol engine, same clock
    input wire logic msg_valid,                      // good frame pulse
    input wire logic [7:0] msg_addr,                 // frame slave address
    // outputs
    output logic [dow_pkg::CHAN_COUNT-1:0] chan_on,  // channel state
    output logic [dow_pkg::CHAN_COUNT-1:0] chan_oe_n, // low: sinking
    output dow_pkg::dow_uart_cfg_type uart_cfg,      // serial settings
    output logic [7:0] slave_addr,                   // bus slave address
    output logic irq                                 // level interrupt
);
    import dow_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [CHAN_COUNT-1:0] chan_q;
    logic forced_q;
    logic [CHAN_COUNT-1:0] init_q;
    logic [WDT_W-1:0] wdt_q;
    logic [7:0] slave_q;
    dow_uart_cfg_type uart_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;

    // ------------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------------
    logic aw_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic w_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_take;
    logic w_take;
    logic aw_have;
    logic w_have;
    logic wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign aw_have = aw_held_q || aw_take;
    assign w_have = w_held_q || w_take;
    assign wr_fire = aw_have && w_have && !bvalid_q;
    assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;

    always_comb begin
        unique case (wr_addr)
            A_OUT, A_INIT, A_WDT, A_SLAVE, A_UART, A_STAT,
            A_IRQ_STAT, A_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // address and data may arrive in either order; each is parked alone
    always_ff @(posedge clk) begin
        if (!rst_n || wr_fire) begin
            aw_held_q <= 1'b0;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || wr_fire) begin
            w_held_q <= 1'b0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    logic [31:0] wr_merged;
    logic wr_out;

    always_comb begin
        unique case (wr_addr)
            A_OUT: wr_merged = merge_bytes(32'(chan_q), wr_data, wr_strb);
            A_INIT: wr_merged = merge_bytes(32'(init_q), wr_data, wr_strb);
            A_WDT: wr_merged = merge_bytes(32'(wdt_q), wr_data, wr_strb);
            A_SLAVE: wr_merged = merge_bytes(32'(slave_q), wr_data, wr_strb);
            A_UART: wr_merged = merge_bytes(32'(uart_q), wr_data, wr_strb);
            A_IRQ_MASK:
                wr_merged = merge_bytes(32'(irq_mask_q), wr_data, wr_strb);
            default: wr_merged = merge_bytes('0, wr_data, wr_strb);
        endcase
    end

    assign wr_out = wr_fire && (wr_addr == A_OUT);

    // ------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------
    logic kick;
    logic sec_tick;
    logic expire;
    dow_wdt_stat_type wdt_stat;

    // any bus access or a frame for our address counts as communication
    assign kick = wr_fire || (s_axi_arvalid && s_axi_arready) ||
                  (msg_valid && msg_addr == slave_q);

    dow_tick_gen #(
        .CYCLES(CYCLES_PER_SEC)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .restart(kick),
        .tick(sec_tick)
    );

    dow_wdt_core u_wdt (
        .clk(clk),
        .rst_n(rst_n),
        .tick(sec_tick),
        .kick(kick),
        .interval(wdt_q),
        .expire(expire),
        .enabled(wdt_stat.enabled),
        .elapsed(wdt_stat.elapsed)
    );

    assign wdt_stat.forced = forced_q;
    assign wdt_stat.pad = '0;

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // an output write is itself a kick and masks expiry, so the write is never overridden
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chan_q <= RST_INIT;
            forced_q <= 1'b0;
        end else if (expire) begin
            chan_q <= init_q;
            forced_q <= 1'b1;
        end else if (wr_out) begin
            chan_q <= wr_merged[CHAN_COUNT-1:0];
            forced_q <= 1'b0;
        end
    end

    assign chan_on = chan_q;

    // open-collector stage: pulling low means the channel is on
    for (genvar g = 0; g < CHAN_COUNT; g++) begin : g_chan
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                chan_oe_n[g] <= ~RST_INIT[g];
            end else begin
                chan_oe_n[g] <= ~chan_q[g];
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            init_q <= RST_INIT;
            wdt_q <= RST_WDT;
            uart_q <= RST_UART;
            irq_mask_q <= '0;
        end else if (wr_fire) begin
            unique case (wr_addr)
                A_INIT: init_q <= wr_merged[CHAN_COUNT-1:0];
                A_WDT: wdt_q <= wr_merged[WDT_W-1:0];
                A_UART: uart_q <= wr_merged[$bits(uart_q)-1:0];
                A_IRQ_MASK: irq_mask_q <= wr_merged[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // addresses outside the legal range are ignored, keeping the old one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slave_q <= RST_SLAVE;
        end else if (wr_fire && wr_addr == A_SLAVE &&
                     wr_merged[7:0] >= SLAVE_MIN &&
                     wr_merged[7:0] <= SLAVE_MAX) begin
            slave_q <= wr_merged[7:0];
        end
    end

    assign uart_cfg = uart_q;
    assign slave_addr = slave_q;

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    assign irq_set = {kick, expire};
    assign irq_clr = (wr_fire && wr_addr == A_IRQ_STAT) ?
                     wr_merged[IRQ_W-1:0] : '0;

    // a new event in the clearing cycle stays set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------------
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rd_val;
    logic rd_hit;

    assign s_axi_arready = !rvalid_q;

    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            A_OUT: rd_val = 32'(chan_q);
            A_INIT: rd_val = 32'(init_q);
            A_WDT: rd_val = 32'(wdt_q);
            A_SLAVE: rd_val = 32'(slave_q);
            A_UART: rd_val = 32'(uart_q);
            A_STAT: rd_val = 32'(wdt_stat);
            A_IRQ_STAT: rd_val = 32'(irq_stat_q);
            A_IRQ_MASK: rd_val = 32'(irq_mask_q);
            default: begin
                rd_val = '0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule : dow_top

`default_nettype wire

// ---- hdl/dow_pkg.sv ----
// Summary of operation
// - fifteen open-collector outputs, each switched on or off by the master.
// - on lost communication the watchdog drives every output to a safe state.
// - the safe pattern is the programmable initial value, not a constant.
// - master sets safe output pattern, watchdog interval and serial settings; power-on state is RST_INIT.
// - factory default slave address 0x01, 9600 baud, no parity, one stop.
// - watchdog counts whole seconds since last message or power-up, then fires.
// - interval 0xFFFF disables the watchdog; outputs are never forced.
// - initial value bit n is channel n state after watchdog expiry, one on, zero off.
`default_nettype none

package dow_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int CHAN_COUNT = 15;
    localparam int ADDR_W = 8;
    localparam int WDT_W = 16;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] A_OUT = 8'h00;
    localparam logic [ADDR_W-1:0] A_INIT = 8'h04;
    localparam logic [ADDR_W-1:0] A_WDT = 8'h08;
    localparam logic [ADDR_W-1:0] A_SLAVE = 8'h0C;
    localparam logic [ADDR_W-1:0] A_UART = 8'h10;
    localparam logic [ADDR_W-1:0] A_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h1C;

    // ------------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------------
    localparam logic [CHAN_COUNT-1:0] RST_INIT = 15'h0000;
    localparam logic [WDT_W-1:0] RST_WDT = 16'hFFFF;
    localparam logic [WDT_W-1:0] WDT_DISABLE = 16'hFFFF;
    localparam logic [7:0] RST_SLAVE = 8'h01;
    localparam logic [7:0] SLAVE_MIN = 8'h01;
    localparam logic [7:0] SLAVE_MAX = 8'hDF;
    localparam logic [3:0] BAUD_9600 = 4'h3;
    localparam logic [1:0] PARITY_NONE = 2'h0;
    localparam logic STOP_ONE = 1'b0;

    // ------------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------------
    typedef struct packed {
        logic stop_two;      // bit 6
        logic [1:0] parity;  // bits 5:4, 0 none 1 odd 2 even
        logic [3:0] baud;    // bits 3:0, rate code
    } dow_uart_cfg_type;

    localparam dow_uart_cfg_type RST_UART = '{
        stop_two: STOP_ONE, parity: PARITY_NONE, baud: BAUD_9600};

    typedef struct packed {
        logic [WDT_W-1:0] elapsed; // bits 31:16, whole seconds
        logic [13:0] pad;          // bits 15:2, read zero
        logic enabled;             // bit 1
        logic forced;              // bit 0
    } dow_wdt_stat_type;

    localparam int IRQ_EXPIRE = 0;
    localparam int IRQ_MSG = 1;
    localparam int IRQ_W = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------------
    localparam int TIMEBASE_S = 1;
    localparam int CLK_FREQ_HZ = 250_000_000;
    localparam int CYCLES_PER_SEC = TIMEBASE_S * CLK_FREQ_HZ;

endpackage : dow_pkg

`default_nettype wire

// ---- hdl/dow_tick_gen.sv ----
`default_nettype none

module dow_tick_gen #(
    parameter int unsigned CYCLES = 250_000_000
) (
    input wire logic clk,     // system clock
    input wire logic rst_n,   // synchronous reset, active low
    input wire logic restart, // realign the second to now
    output logic tick         // one-cycle pulse per second
);
    import dow_pkg::*;

    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;

    // restarting keeps the seconds whole from the last message
    always_ff @(posedge clk) begin
        if (!rst_n || restart || cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign tick = (cnt_q == LAST) && !restart;

endmodule : dow_tick_gen

`default_nettype wire

// ---- hdl/dow_wdt_core.sv ----
`default_nettype none

module dow_wdt_core (
    input wire logic clk,                        // system clock
    input wire logic rst_n,                      // sync reset, active low
    input wire logic tick,                       // one-second pulse
    input wire logic kick,                       // message seen
    input wire logic [dow_pkg::WDT_W-1:0] interval, // seconds
    output logic expire,                         // one-cycle expiry pulse
    output logic enabled,                        // interval not disabled
    output logic [dow_pkg::WDT_W-1:0] elapsed    // seconds since message
);
    import dow_pkg::*;

    logic [WDT_W-1:0] elapsed_q;
    logic fired_q;

    assign enabled = (interval != WDT_DISABLE);
    assign elapsed = elapsed_q;

    // count saturates so a long silence never wraps into a false restart
    always_ff @(posedge clk) begin
        if (!rst_n || kick) begin
            elapsed_q <= '0;
        end else if (tick && elapsed_q != WDT_DISABLE) begin
            elapsed_q <= elapsed_q + 1'b1;
        end
    end

    // fires once per silent period
    assign expire = enabled && !fired_q && !kick &&
                    (elapsed_q >= interval);

    always_ff @(posedge clk) begin
        if (!rst_n || kick) begin
            fired_q <= 1'b0;
        end else if (expire) begin
            fired_q <= 1'b1;
        end
    end

endmodule : dow_wdt_core

`default_nettype wire

// ---- verif/dow_checker.sv ----
`default_nettype none

module dow_checker
    import dow_pkg::*;
(
    input wire logic clk,                        // clock
    input wire logic rst_n,                      // sync reset, low
    input wire logic s_axi_awvalid,              // write addr valid
    input wire logic s_axi_awready,              // write addr ready
    input wire logic s_axi_wvalid,               // write data valid
    input wire logic s_axi_wready,               // write data ready
    input wire logic s_axi_bvalid,               // response valid
    input wire logic s_axi_bready,               // response ready
    input wire logic s_axi_arvalid,              // read addr valid
    input wire logic s_axi_arready,              // read addr ready
    input wire logic s_axi_rvalid,               // read data valid
    input wire logic s_axi_rready,               // read data ready
    input wire logic [dow_pkg::CHAN_COUNT-1:0] chan_on,   // state
    input wire logic [dow_pkg::CHAN_COUNT-1:0] chan_oe_n, // enable
    input wire dow_pkg::dow_uart_cfg_type uart_cfg,       // serial
    input wire logic [7:0] slave_addr,           // slave address
    input wire logic irq                         // interrupt
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    oe_lag_a: assert property (chan_oe_n == ~$past(chan_on))
        else $error("output enable does not track channel state");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read data late");
    wr_block_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid)
        else $error("response kept after handshake");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid)
        else $error("read data kept after handshake");
    boot_cfg_a: assert property ($rose(rst_n)
        |-> slave_addr == RST_SLAVE && uart_cfg == RST_UART)
        else $error("factory serial settings wrong after reset");
    slave_rng_a: assert property (slave_addr >= SLAVE_MIN
        && slave_addr <= SLAVE_MAX)
        else $error("slave address out of range");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($rose(irq));
    cover property ($changed(chan_on));
endmodule : dow_checker

bind dow_top dow_checker dow_checker_inst (.*);

`default_nettype wire

// ---- verif/dow_host_model.sv ----
`default_nettype none

module dow_host_model (
    input wire logic clk,             // clock
    input wire logic rst_n,           // sync reset, low
    input wire logic send,            // emit one frame now
    input wire logic [7:0] send_addr, // address of that frame
    output logic msg_valid,           // good frame pulse
    output logic [7:0] msg_addr       // frame slave address
);
    // between frames the address wanders so a stale value never helps
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            msg_valid <= 1'b0;
            msg_addr <= 8'hA5;
        end else begin
            msg_valid <= send;
            msg_addr <= send ? send_addr : ~msg_addr;
        end
    end
endmodule : dow_host_model

`default_nettype wire

// ---- verif/digital_output_comm_watchdog_tb.sv ----
`default_nettype none

module digital_output_comm_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dow_pkg::*;
    localparam int CPS = 10;
    logic clk, rst_n, send, irq, msg_valid;
    logic [7:0] send_addr, msg_addr, slave_addr, s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [CHAN_COUNT-1:0] chan_on, chan_oe_n;
    dow_uart_cfg_type uart_cfg;
    int num_errors = 0;
    int check_count = 0;

    dow_top #(.CYCLES_PER_SEC(CPS)) dow_top_inst (.*);
    dow_host_model dow_host_model_inst (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic conclude();
        if (num_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        logic ta, tw;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            if (s_axi_bvalid) break;
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        if (n == 40) begin
            cmp("write timeout", 1, 0);
            conclude();
        end
        r = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        logic ta;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            if (s_axi_rvalid) break;
            ta = s_axi_arvalid && s_axi_arready;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        if (n == 40) begin
            cmp("read timeout", 1, 0);
            conclude();
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic wrc(input logic [7:0] a, input logic [31:0] v);
        wr(a, v);
        cmp("bresp", RESP_OKAY, r);
    endtask : wrc

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        rd(a);
        cmp(nm, e, d);
        cmp("rresp", RESP_OKAY, r);
    endtask : rdc

    task automatic frames(input logic [7:0] a, input int k);
        repeat (k) begin
            repeat (CPS) @(posedge clk);
            send <= 1'b1;
            send_addr <= a;
            @(posedge clk);
            send <= 1'b0;
        end
        @(negedge clk);
    endtask : frames

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        rst_n = 1'b0;
        send = 1'b0;
        send_addr = 8'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdc("out", A_OUT, 32'h0);
        rdc("init", A_INIT, 32'h0);
        rdc("interval", A_WDT, 32'h0000FFFF);
        rdc("slave", A_SLAVE, 32'h1);
        rdc("uart", A_UART, 32'h3);
        rdc("status", A_STAT, 32'h0);
        rdc("mask", A_IRQ_MASK, 32'h0);
        cmp("chan_oe_n", 32'h7FFF, chan_oe_n);
        rd(8'h20);
        cmp("rresp unmapped", RESP_SLVERR, r);
        cmp("rdata unmapped", 32'h0, d);
        wr(8'h24, 32'h1);
        cmp("bresp unmapped", RESP_SLVERR, r);
        wrc(A_OUT, 32'h5A5A);
        @(negedge clk);
        cmp("chan_on", 32'h5A5A, chan_on);
        cmp("chan_oe_n", 32'h25A5, chan_oe_n);
        wrc(A_SLAVE, 32'hE0);
        rdc("slave", A_SLAVE, 32'h1);
        wrc(A_SLAVE, 32'h22);
        rdc("slave", A_SLAVE, 32'h22);
        cmp("slave_addr", 32'h22, slave_addr);
        wrc(A_UART, 32'h45);
        rdc("uart", A_UART, 32'h45);
        cmp("uart_cfg", 32'h45, uart_cfg);
        // silent period: outputs must hold, then fall back to the pattern
        wrc(A_IRQ_MASK, 32'h1);
        wrc(A_INIT, 32'h1234);
        wrc(A_WDT, 32'h2);
        repeat (2 * CPS - 4) @(negedge clk);
        cmp("chan_on early", 32'h5A5A, chan_on);
        for (n = 0; n < 12 && chan_on !== 15'h1234; n++) @(negedge clk);
        cmp("chan_on forced", 32'h1234, chan_on);
        cmp("irq", 32'h1, irq);
        @(negedge clk);
        cmp("chan_oe_n", 32'h6DCB, chan_oe_n);
        rd(A_STAT);
        cmp("status", 32'h3, d & 32'h3);
        rd(A_IRQ_STAT);
        cmp("irq status", 32'h3, d & 32'h3);
        wrc(A_IRQ_STAT, 32'h1);
        @(negedge clk);
        cmp("irq cleared", 32'h0, irq);
        repeat (3 * CPS) @(negedge clk);
        cmp("chan_on held", 32'h1234, chan_on);
        // frames to this slave keep it alive, foreign ones do not
        wrc(A_OUT, 32'h0F0F);
        frames(8'h22, 6);
        cmp("chan_on kept", 32'h0F0F, chan_on);
        frames(8'h05, 3);
        cmp("chan_on lost", 32'h1234, chan_on);
        wrc(A_WDT, 32'hFFFF);
        wrc(A_OUT, 32'h7FFF);
        repeat (5 * CPS) @(negedge clk);
        cmp("chan_on off", 32'h7FFF, chan_on);
        rd(A_STAT);
        // five whole seconds since the last write, nothing forced
        cmp("status", 32'h00050000, d);
        conclude();
    end
endmodule : digital_output_comm_watchdog_tb

`default_nettype wire
